// ---- hdl/bms_top.sv ----
// boot mode select: samples the straps during reset and drives the boot select pin
// assumes one clock, synchronous active-high reset, straps tied by the board
// Functional notes
// - memory strap high and link strap low selects 8-bit memory boot with the select pin as chip select.
// - both straps low with select input high selects host boot.
// - memory strap low, link strap high and select input high selects link port boot.
// - both straps low with select input low means no boot and run from external memory.
// - the select pin is three-stated in every mode except memory boot mode, where it is an output while this end owns the bus.
// - only the current bus owner drives the select pin; others leave it undriven.
// - one instruction cycle per clock period with no multiplication or division.
// - with the memory strap low, the mode comes from link strap and select input together.
`timescale 1ns/100ps
`default_nettype none
`include "bms_regs.svh"
module bms_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic memory_boot_strap,
	input wire logic link_boot_strap,
	input wire logic boot_memory_select_i,
	input wire logic bus_owner,
	input wire logic boot_cs_active,
	output logic boot_memory_select_o,
	output logic boot_memory_select_oe,
	output var bms_pkg::bms_mode_t boot_mode,
	output logic mode_valid,
	output logic mode_reserved,
	output logic instr_tick
);
	bms_pkg::bms_straps_t straps;
	bms_pkg::bms_mode_t decoded;
	bms_pkg::bms_pin_t next_pin;
	assign straps = '{memory_boot_strap: memory_boot_strap,
		link_boot_strap: link_boot_strap,
		boot_memory_select: boot_memory_select_i};

	bms_decode u_decode (
		.straps(straps),
		.mode(decoded)
	);

	// capture straps while reset is held; frozen afterwards
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			boot_mode <= decoded;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_valid <= `BMS_SAMPLED_RST;
		end else begin
			mode_valid <= 1'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_reserved <= (decoded == bms_pkg::BMS_MODE_RESERVED);
		end
	end

	// pin drives only in memory boot mode, and only when this end owns the bus
	always_comb begin
		next_pin.sel_oe = (boot_mode == bms_pkg::BMS_MODE_MEMORY)
			&& bus_owner;
		// chip select stays high whenever this end is not the owner
		next_pin.sel_o = ~(boot_cs_active && bus_owner);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			boot_memory_select_oe <= `BMS_PIN_OE_RST;
			boot_memory_select_o <= `BMS_PIN_O_RST;
		end else begin
			boot_memory_select_oe <= next_pin.sel_oe;
			boot_memory_select_o <= next_pin.sel_o;
		end
	end

	// one instruction slot per clock, no division
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			instr_tick <= `BMS_TICK_RST;
		end else begin
			instr_tick <= 1'h1;
		end
	end

	property p_mode_hold;
		@(posedge sys_clk) disable iff (rst)
		mode_valid |-> $stable(boot_mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed after reset");

	property p_oe_mem_only;
		@(posedge sys_clk) disable iff (rst)
		boot_memory_select_oe |-> boot_mode == bms_pkg::BMS_MODE_MEMORY;
	endproperty
	a_oe_mem_only: assert property (p_oe_mem_only) else $error("pin driven outside memory boot");

	property p_owner;
		@(posedge sys_clk) disable iff (rst)
		mode_valid && !$past(bus_owner) |-> !boot_memory_select_oe;
	endproperty
	a_owner: assert property (p_owner) else $error("pin driven by non owner");

	property p_oe_follows;
		@(posedge sys_clk) disable iff (rst)
		mode_valid && boot_mode == bms_pkg::BMS_MODE_MEMORY && bus_owner
			|=> boot_memory_select_oe;
	endproperty
	a_oe_follows: assert property (p_oe_follows) else $error("owner in memory mode not driving");

	property p_cs;
		@(posedge sys_clk) disable iff (rst)
		boot_cs_active && bus_owner |=> !boot_memory_select_o;
	endproperty
	a_cs: assert property (p_cs) else $error("chip select not asserted");

	property p_host;
		@(posedge sys_clk)
		rst && !memory_boot_strap && !link_boot_strap && boot_memory_select_i
			|=> boot_mode == bms_pkg::BMS_MODE_HOST;
	endproperty
	a_host: assert property (p_host) else $error("host mode not decoded");

	property p_link;
		@(posedge sys_clk)
		rst && !memory_boot_strap && link_boot_strap && boot_memory_select_i
			|=> boot_mode == bms_pkg::BMS_MODE_LINK;
	endproperty
	a_link: assert property (p_link) else $error("link mode not decoded");

	property p_none;
		@(posedge sys_clk)
		rst && !memory_boot_strap && !link_boot_strap && !boot_memory_select_i
			|=> boot_mode == bms_pkg::BMS_MODE_NONE;
	endproperty
	a_none: assert property (p_none) else $error("no boot mode not decoded");

	property p_tick;
		@(posedge sys_clk) disable iff (rst)
		mode_valid |-> instr_tick [*2];
	endproperty
	a_tick: assert property (p_tick) else $error("instruction tick missing");

	property p_rst_outputs;
		@(posedge sys_clk)
		rst |=> !boot_memory_select_oe && boot_memory_select_o
			&& !mode_valid && !instr_tick;
	endproperty
	a_rst_outputs: assert property (p_rst_outputs) else $error("outputs not at reset values");

	property p_mem_decode;
		@(posedge sys_clk)
		rst && memory_boot_strap && !link_boot_strap
			|=> boot_mode == bms_pkg::BMS_MODE_MEMORY;
	endproperty
	a_mem_decode: assert property (p_mem_decode) else $error("memory boot not decoded");

	property p_rsv_both;
		@(posedge sys_clk)
		rst && memory_boot_strap && link_boot_strap
			|=> boot_mode == bms_pkg::BMS_MODE_RESERVED && mode_reserved;
	endproperty
	a_rsv_both: assert property (p_rsv_both) else $error("both straps high not flagged");

	property p_rsv_link;
		@(posedge sys_clk)
		rst && !memory_boot_strap && link_boot_strap && !boot_memory_select_i
			|=> boot_mode == bms_pkg::BMS_MODE_RESERVED && mode_reserved;
	endproperty
	a_rsv_link: assert property (p_rsv_link) else $error("link with select low not flagged");

	property p_valid;
		@(posedge sys_clk)
		!rst |=> mode_valid && instr_tick;
	endproperty
	a_valid: assert property (p_valid) else $error("mode valid missing out of reset");

	property p_rsv_flag;
		@(posedge sys_clk) disable iff (rst)
		mode_valid |-> mode_reserved == (boot_mode == bms_pkg::BMS_MODE_RESERVED);
	endproperty
	a_rsv_flag: assert property (p_rsv_flag) else $error("reserved flag disagrees with mode");

	property p_rsv_hold;
		@(posedge sys_clk) disable iff (rst)
		mode_valid |-> $stable(mode_reserved);
	endproperty
	a_rsv_hold: assert property (p_rsv_hold) else $error("reserved flag changed after reset");

	property p_oe_clear;
		@(posedge sys_clk) disable iff (rst)
		!bus_owner |=> !boot_memory_select_oe;
	endproperty
	a_oe_clear: assert property (p_oe_clear) else $error("pin driven after bus loss");

	property p_cs_idle;
		@(posedge sys_clk) disable iff (rst)
		!(boot_cs_active && bus_owner) |=> boot_memory_select_o;
	endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("chip select low while idle");

	property p_mem_drive;
		@(posedge sys_clk) disable iff (rst)
		mode_valid && boot_mode == bms_pkg::BMS_MODE_MEMORY && bus_owner && boot_cs_active
			|=> boot_memory_select_oe && !boot_memory_select_o;
	endproperty
	a_mem_drive: assert property (p_mem_drive) else $error("boot memory not selected");

	c_mem: cover property (@(posedge sys_clk) boot_memory_select_oe && !boot_memory_select_o);
	c_link: cover property (@(posedge sys_clk) mode_valid && boot_mode == bms_pkg::BMS_MODE_LINK);
	c_host: cover property (@(posedge sys_clk) mode_valid && boot_mode == bms_pkg::BMS_MODE_HOST);
	c_rsv: cover property (@(posedge sys_clk) mode_valid && mode_reserved);
	c_none: cover property (@(posedge sys_clk) mode_valid && boot_mode == bms_pkg::BMS_MODE_NONE);
endmodule
`default_nettype wire

// ---- inc/bms_regs.svh ----
// constants for the boot mode select block
// assumes inclusion by the design files bms_top and bms_decode
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH
`define BMS_STRAP_MEM 2
`define BMS_STRAP_LINK 1
`define BMS_STRAP_SEL 0
`define BMS_SAMPLED_RST 1'h0
`define BMS_PIN_OE_RST 1'h0
`define BMS_PIN_O_RST 1'h1
`define BMS_TICK_RST 1'h0
`endif

// ---- inc/bms_pkg.sv ----
// types for the boot mode select block
// assumes bms_regs.svh is on the include path
package bms_pkg;
	typedef enum logic [2:0] {
		BMS_MODE_MEMORY = 3'h0,
		BMS_MODE_HOST = 3'h1,
		BMS_MODE_LINK = 3'h2,
		BMS_MODE_NONE = 3'h3,
		BMS_MODE_RESERVED = 3'h4
	} bms_mode_t;
	typedef struct packed {
		logic memory_boot_strap;
		logic link_boot_strap;
		logic boot_memory_select;
	} bms_straps_t;
	typedef struct packed {
		logic sel_o;
		logic sel_oe;
	} bms_pin_t;
endpackage

// ---- hdl/bms_decode.sv ----
// strap decoder: combinational mapping of straps to a boot mode
// assumes straps are sampled by the caller
`timescale 1ns/100ps
`default_nettype none
`include "bms_regs.svh"
module bms_decode (
	input wire bms_pkg::bms_straps_t straps,
	output var bms_pkg::bms_mode_t mode
);
	always_comb begin
		if (straps.memory_boot_strap) begin
			// link strap high with memory strap high is reserved
			mode = straps.link_boot_strap ? bms_pkg::BMS_MODE_RESERVED
				: bms_pkg::BMS_MODE_MEMORY;
		end else begin
			unique case ({straps.link_boot_strap, straps.boot_memory_select})
				2'h1: mode = bms_pkg::BMS_MODE_HOST;
				2'h3: mode = bms_pkg::BMS_MODE_LINK;
				2'h0: mode = bms_pkg::BMS_MODE_NONE;
				default: mode = bms_pkg::BMS_MODE_RESERVED;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- dv/bms_board.sv ----
// board model: strap resistors and the shared select wire
// assumes the pin enable is high while the block drives the pin
`timescale 1ns/100ps
`default_nettype none
module bms_board (
	input wire bms_pkg::bms_straps_t straps,
	input wire logic pin_o,
	input wire logic pin_oe,
	output logic sel_i
);
	// straps stay tied; the wire follows the block while it drives
	assign sel_i = pin_oe ? pin_o : straps.boot_memory_select;
endmodule
`default_nettype wire

// ---- dv/test_boot_mode_select.sv ----
// bench for the boot mode select block: every strap combination
// assumes bms_top with synchronous active-high reset and a 4 ns clock
`timescale 1ns/100ps
`default_nettype none
module test_boot_mode_select;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic owner = 1'h0;
	logic cs = 1'h0;
	logic sel_i, sel_o, sel_oe, valid, rsv, tick;
	bms_pkg::bms_straps_t straps = 3'h0;
	bms_pkg::bms_mode_t mode;
	logic [7:0] q[$];
	int error_cnt = 0;
	int compares = 0;
	int seed = 23347;
	bms_top bms_top_inst (.sys_clk(sys_clk), .rst(rst),
		.memory_boot_strap(straps.memory_boot_strap),
		.link_boot_strap(straps.link_boot_strap), .boot_memory_select_i(sel_i),
		.bus_owner(owner), .boot_cs_active(cs), .boot_memory_select_o(sel_o),
		.boot_memory_select_oe(sel_oe), .boot_mode(mode), .mode_valid(valid),
		.mode_reserved(rsv), .instr_tick(tick));
	bms_board bms_board_inst (.straps(straps), .pin_o(sel_o), .pin_oe(sel_oe), .sel_i(sel_i));
	initial forever #2 sys_clk = ~sys_clk;
	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic [2:0] exp_mode(input logic [2:0] s);
		if (s[2]) return s[1] ? 3'h4 : 3'h0;
		case (s[1:0])
			2'h1: return 3'h1;
			2'h3: return 3'h2;
			2'h0: return 3'h3;
			default: return 3'h4;
		endcase
	endfunction
	// monitor: oldest note against what the outputs show
	always @(posedge sys_clk) begin
		#0.5;
		if (q.size() > 0) check({mode, rsv, valid, tick, sel_oe, sel_o}, q.pop_front());
	end
	initial begin
		#5000;
		error_cnt++;
		stop_test();
	end
	initial begin
		logic [2:0] m;
		for (int s = 0; s < 8; s++) begin
			@(posedge sys_clk);
			#1;
			rst = 1'h1;
			straps = 3'(s);
			m = exp_mode(3'(s));
			repeat (9) @(posedge sys_clk);
			#1;
			q.push_back({m, m == 3'h4, 4'h1});
			@(posedge sys_clk);
			#1;
			rst = 1'h0;
			for (int i = 0; i < 40; i++) begin
				owner = 1'($random(seed));
				cs = 1'($random(seed));
				// straps wander after release; the mode must not follow
				if (i > 20) straps = 3'($random(seed));
				q.push_back({m, m == 3'h4, 2'h3, m == 3'h0 && owner, !(owner && cs)});
				@(posedge sys_clk);
				#1;
			end
		end
		repeat (2) @(posedge sys_clk);
		stop_test();
	end
endmodule
`default_nettype wire
